// ---- logic/mmno_pkg.sv ----
package mmno_pkg;

    // Opcode patterns, compared against the top bits of the instruction word.
    localparam logic [6:0] OPC_MOVWF7 = 7'h37;  // 0110 111a
    localparam logic [6:0] OPC_NEGF7  = 7'h36;  // 0110 110a
    localparam logic [7:0] OPC_MULLW8 = 8'h0d;  // 0000 1101
    localparam logic [6:0] OPC_MULWF7 = 7'h01;  // 0000 001a
    localparam logic [3:0] OPC_NOP_HI = 4'hf;   // 1111 xxxx
    localparam logic [15:0] OPC_NOP_ZERO = 16'h0000;

    // Instruction field positions.
    localparam int unsigned ACC_BIT = 8;

    // Operand addressing constants.
    localparam logic [7:0] ILO_MAX      = 8'h5f;
    localparam logic [7:0] ACC_SPLIT    = 8'h60;
    localparam logic [5:0] ACC_LOW_BANK = 6'h00;
    localparam logic [5:0] ACC_HI_BANK  = 6'h3f;

    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] REG_WORK  = 8'h00;
    localparam logic [7:0] REG_BANK  = 8'h04;
    localparam logic [7:0] REG_CTRL  = 8'h08;
    localparam logic [7:0] REG_INDEX = 8'h0c;
    localparam logic [7:0] REG_PROD  = 8'h10;
    localparam logic [7:0] REG_STAT  = 8'h14;
    localparam logic [7:0] REG_CORE  = 8'h18;

    // Status register bit positions.
    localparam int unsigned ST_C  = 0;
    localparam int unsigned ST_DC = 1;
    localparam int unsigned ST_Z  = 2;
    localparam int unsigned ST_OV = 3;
    localparam int unsigned ST_N  = 4;

    // Reset values.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } mmno_phase_t;

    typedef enum logic [4:0] {
        OP_NOP   = 5'b00001,
        OP_MOVE_WORKING_TO_FILE = 5'b00010,
        OP_MULTIPLY_LITERAL_OP = 5'b00100,
        OP_MULTIPLY_FILE_OP = 5'b01000,
        OP_NEGATE_FILE_OP  = 5'b10000
    } mmno_op_t;

    // Request from the core to the data register file.
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0]  wdata;
        logic        we;
    } mmno_dmem_req_t;

endpackage

// ---- logic/mmno_core.sv ----
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
// How it works
// - Move-working-to-file copies the working register into the file register, flags kept.
// - The 8-bit file field reaches every byte of a 256-byte bank.
// - Access bit zero selects access bank; one uses the bank select register.
// - Access bit zero, extended set on, operand up to 95: indexed literal offset.
// - Multiply literal puts working times literal into product pair, high byte upper.
// - Multiply file puts working times file register into product pair, sources kept.
// - Both multiplies leave every status flag untouched, even for a zero product.
// - Negate writes inverted value plus one back, updating N, OV, C, DC, Z.
module mmno_core
    import mmno_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic [15:0]    instr_i,
    input  wire logic           instr_valid_i,
    output logic                instr_ready_o,
    output mmno_dmem_req_t      dmem_o,
    input  wire logic [7:0]     dmem_rdata_i,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    input  wire logic           wb_we_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic [31:0]    wb_dat_i,
    output logic [31:0]         wb_dat_o,
    output logic                wb_ack_o
);

    typedef struct packed {
        mmno_phase_t    phase;
        mmno_op_t       op;
        logic [15:0]    ir;
        logic [7:0]     work;
        logic [5:0]     bank_select_register;
        logic           ext_en;
        logic [13:0]    idx_base;
        logic [15:0]    prod;
        logic [4:0]     status;
        logic [7:0]     opnd;
        logic [4:0]     new_flags;
        logic           ilo;
        logic           rdy;
        mmno_dmem_req_t dmem;
        logic           ack;
        logic [31:0]    dat;
    } mmno_state_t;

    mmno_state_t s_q;
    mmno_state_t s_d;

    logic        bus_req;
    logic        bus_wr;
    logic [7:0]  f_fld;
    logic        a_fld;
    logic [7:0]  neg_res;

    // Merge a written low byte and high byte under the Wishbone byte selects.
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] dat,
                                               input logic [3:0] sel);
        lane_merge = old_v;
        if (sel[0]) begin
            lane_merge[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = dat[15:8];
        end
    endfunction

    // A request is answered exactly once; ack high blocks a second take of the same request.
    // A write commits at the edge where the master samples ack, so an abandoned cycle writes nothing.
    assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;
    assign f_fld   = s_q.ir[7:0];
    assign a_fld   = s_q.ir[ACC_BIT];
    assign neg_res = 8'(~s_q.opnd + 8'h01);

    // Next-state logic for the whole core: bus slave first, instruction effects after so they win.
    always_comb begin
        logic [15:0] m;
        logic [7:0]  f_in;
        m    = RST_HALF;
        f_in = instr_i[7:0];
        s_d  = s_q;
        s_d.ack = bus_req;
        s_d.dat = RST_WORD;
        s_d.dmem.we = 1'b0;

        // Register reads return the state seen in the cycle of the request.
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                REG_WORK:  s_d.dat = {24'h000000, s_q.work};
                REG_BANK:  s_d.dat = {26'h0000000, s_q.bank_select_register};
                REG_CTRL:  s_d.dat = {31'h00000000, s_q.ext_en};
                REG_INDEX: s_d.dat = {18'h00000, s_q.idx_base};
                REG_PROD:  s_d.dat = {16'h0000, s_q.prod};
                REG_STAT:  s_d.dat = {27'h0000000, s_q.status};
                REG_CORE:  s_d.dat = {22'h000000, s_q.rdy, s_q.op, s_q.phase};
                default:   s_d.dat = RST_WORD;
            endcase
        end

        // Register writes; unmapped offsets are acknowledged and dropped.
        if (bus_wr) begin
            unique case (wb_adr_i)
                REG_WORK: begin
                    m = lane_merge({8'h00, s_q.work}, wb_dat_i, wb_sel_i);
                    s_d.work = m[7:0];
                end
                REG_BANK: begin
                    m = lane_merge({10'h000, s_q.bank_select_register}, wb_dat_i, wb_sel_i);
                    s_d.bank_select_register = m[5:0];
                end
                REG_CTRL: begin
                    m = lane_merge({15'h0000, s_q.ext_en}, wb_dat_i, wb_sel_i);
                    s_d.ext_en = m[0];
                end
                REG_INDEX: begin
                    m = lane_merge({2'h0, s_q.idx_base}, wb_dat_i, wb_sel_i);
                    s_d.idx_base = m[13:0];
                end
                REG_PROD: s_d.prod = lane_merge(s_q.prod, wb_dat_i, wb_sel_i);
                REG_STAT: begin
                    m = lane_merge({11'h000, s_q.status}, wb_dat_i, wb_sel_i);
                    s_d.status = m[4:0];
                end
                default: s_d.dat = RST_WORD;
            endcase
        end

        // The four-phase ring runs free; an instruction is only taken at the first quarter.
        unique case (s_q.phase)
            PH_Q1: begin
                s_d.phase = PH_Q2;
                s_d.op    = OP_NOP;
                s_d.ir    = OPC_NOP_ZERO;
                s_d.ilo   = 1'b0;
                if (instr_valid_i) begin
                    s_d.ir = instr_i;
                    // Top bits pick the operation; anything not listed runs as a no-operation.
                    if (instr_i[15:9] == OPC_MOVWF7) begin
                        s_d.op = OP_MOVE_WORKING_TO_FILE;
                    end else if (instr_i[15:9] == OPC_NEGF7) begin
                        s_d.op = OP_NEGATE_FILE_OP;
                    end else if (instr_i[15:8] == OPC_MULLW8) begin
                        s_d.op = OP_MULTIPLY_LITERAL_OP;
                    end else if (instr_i[15:9] == OPC_MULWF7) begin
                        s_d.op = OP_MULTIPLY_FILE_OP;
                    end else begin
                        s_d.op = OP_NOP;
                    end
                    // Operand address, fixed for the rest of the cycle.
                    if (instr_i[ACC_BIT]) begin
                        s_d.dmem.addr = {s_q.bank_select_register, f_in};
                    end else if (s_q.ext_en && f_in <= ILO_MAX) begin
                        s_d.ilo = 1'b1;
                        s_d.dmem.addr = 14'(s_q.idx_base + {6'h00, f_in});
                    end else if (f_in < ACC_SPLIT) begin
                        s_d.dmem.addr = {ACC_LOW_BANK, f_in};
                    end else begin
                        s_d.dmem.addr = {ACC_HI_BANK, f_in};
                    end
                end
            end
            PH_Q2: begin
                s_d.phase = PH_Q3;
                // File read data is combinational, so it is caught at the end of the second quarter.
                s_d.opnd  = dmem_rdata_i;
            end
            PH_Q3: begin
                s_d.phase = PH_Q4;
                // Flags for negate are worked out here so the fourth quarter only commits.
                s_d.new_flags[ST_C]  = (s_q.opnd == RST_BYTE);
                s_d.new_flags[ST_DC] = (s_q.opnd[3:0] == 4'h0);
                s_d.new_flags[ST_Z]  = (neg_res == RST_BYTE);
                s_d.new_flags[ST_OV] = (s_q.opnd == 8'h80);
                s_d.new_flags[ST_N]  = neg_res[7];
                if (s_q.op == OP_MOVE_WORKING_TO_FILE) begin
                    s_d.dmem.we    = 1'b1;
                    s_d.dmem.wdata = s_q.work;
                end else if (s_q.op == OP_NEGATE_FILE_OP) begin
                    s_d.dmem.we    = 1'b1;
                    s_d.dmem.wdata = neg_res;
                end
            end
            PH_Q4: begin
                s_d.phase = PH_Q1;
                // Product and flags committed here override a bus write in the same cycle.
                if (s_q.op == OP_MULTIPLY_LITERAL_OP) begin
                    s_d.prod = 16'(s_q.work * f_fld);
                end else if (s_q.op == OP_MULTIPLY_FILE_OP) begin
                    s_d.prod = 16'(s_q.work * s_q.opnd);
                end else if (s_q.op == OP_NEGATE_FILE_OP) begin
                    s_d.status = s_q.new_flags;
                end
            end
        endcase
        s_d.rdy = (s_d.phase == PH_Q1);
    end

    // Single state register; synchronous reset to constants.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{phase: PH_Q1, op: OP_NOP, ir: RST_HALF, work: RST_BYTE, bank_select_register: 6'h00,
                     ext_en: 1'b0, idx_base: 14'h0000, prod: RST_HALF, status: 5'h00,
                     opnd: RST_BYTE, new_flags: 5'h00, ilo: 1'b0, rdy: 1'b1,
                     dmem: '{addr: 14'h0000, wdata: RST_BYTE, we: 1'b0}, ack: 1'b0, dat: RST_WORD};
        end else begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the state register, so none carries a combinational path.
    assign instr_ready_o = s_q.rdy;
    assign dmem_o        = s_q.dmem;
    assign wb_dat_o      = s_q.dat;
    assign wb_ack_o      = s_q.ack;

    // Helper terms read only by the checks below.
    logic stat_bus_wr;
    logic prod_bus_wr;
    assign stat_bus_wr = bus_wr && wb_adr_i == REG_STAT;
    assign prod_bus_wr = bus_wr && wb_adr_i == REG_PROD;

    // Checks on what the core drives; the bus and the instruction port come from outside.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    phase_ring_a: assert property (
        s_q.phase == PH_Q1 |=> s_q.phase == PH_Q2 ##1 s_q.phase == PH_Q3 ##1 s_q.phase == PH_Q4
        ##1 s_q.phase == PH_Q1)
        else $error("Four-phase ring broken.");

    move_write_a: assert property (
        s_q.phase == PH_Q4 && s_q.op == OP_MOVE_WORKING_TO_FILE |-> dmem_o.we && dmem_o.wdata == $past(s_q.work))
        else $error("Move did not write the working register.");

    flags_kept_a: assert property (
        s_q.phase == PH_Q4 && s_q.op != OP_NEGATE_FILE_OP && !stat_bus_wr |=> $stable(s_q.status))
        else $error("Status changed on a flag-neutral instruction.");

    bank_byte_a: assert property (
        s_q.phase == PH_Q2 && s_q.op != OP_NOP && !s_q.ilo |-> dmem_o.addr[7:0] == f_fld)
        else $error("File field not placed in the bank offset.");

    bank_select_a: assert property (
        s_q.phase == PH_Q2 && s_q.op != OP_NOP && a_fld |-> dmem_o.addr[13:8] == $past(s_q.bank_select_register))
        else $error("Banked access ignored the bank select register.");

    indexed_addr_a: assert property (
        s_q.phase == PH_Q2 && s_q.op != OP_NOP && !a_fld && $past(s_q.ext_en) && f_fld <= ILO_MAX
        |-> s_q.ilo && dmem_o.addr == 14'($past(s_q.idx_base) + {6'h00, f_fld}))
        else $error("Indexed literal offset address wrong.");

    mul_lit_a: assert property (
        s_q.phase == PH_Q4 && s_q.op == OP_MULTIPLY_LITERAL_OP |=> s_q.prod == 16'($past(s_q.work) * $past(f_fld))
        && s_q.work == $past(s_q.work))
        else $error("Literal product wrong.");

    mul_file_a: assert property (
        s_q.phase == PH_Q4 && s_q.op == OP_MULTIPLY_FILE_OP
        |-> !dmem_o.we ##1 s_q.prod == 16'($past(s_q.work) * $past(s_q.opnd)))
        else $error("File product wrong or source overwritten.");

    negate_flags_a: assert property (
        s_q.phase == PH_Q4 && s_q.op == OP_NEGATE_FILE_OP |-> dmem_o.we && dmem_o.wdata == 8'(~s_q.opnd + 8'h01)
        ##1 s_q.status[ST_Z] == ($past(dmem_o.wdata) == RST_BYTE) && s_q.status[ST_C] == s_q.status[ST_Z])
        else $error("Negate result or flags wrong.");

    nop_quiet_a: assert property (
        s_q.phase == PH_Q4 && s_q.op == OP_NOP && !prod_bus_wr && !stat_bus_wr
        |-> !dmem_o.we ##1 $stable(s_q.prod) && $stable(s_q.status))
        else $error("No-operation changed state.");

    bus_ack_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle.");

    ack_one_cycle_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Request not answered in the next cycle.");

    dat_idle_a: assert property (
        !wb_ack_o |-> wb_dat_o == RST_WORD)
        else $error("Read data not zero outside acknowledge.");

    write_at_ack_a: assert property (
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_WORK
        |=> s_q.work == $past(wb_dat_i[7:0]))
        else $error("Working register write did not land at acknowledge.");

    ready_phase_a: assert property (
        instr_ready_o == (s_q.phase == PH_Q1))
        else $error("Ready not tied to the first quarter.");

    cov_move_working_to_file_c: cover property (s_q.phase == PH_Q4 && s_q.op == OP_MOVE_WORKING_TO_FILE);
    cov_multiply_literal_op_c: cover property (s_q.phase == PH_Q4 && s_q.op == OP_MULTIPLY_LITERAL_OP && s_q.work != RST_BYTE);
    cov_negate_file_op_ov_c: cover property (s_q.phase == PH_Q4 && s_q.op == OP_NEGATE_FILE_OP && s_q.new_flags[ST_OV]);
    cov_ilo_c: cover property (s_q.phase == PH_Q2 && s_q.ilo);
    cov_multiply_file_op_c: cover property (s_q.phase == PH_Q4 && s_q.op == OP_MULTIPLY_FILE_OP);

endmodule

// ---- verif/mmno_dfile_model.sv ----
`timescale 1ns/1ns
// Data register file seen by the core: 16K bytes, read without delay, written at the clock edge.
module mmno_dfile_model
    import mmno_pkg::*;
(
    input  wire logic       clk_i,
    input  mmno_dmem_req_t  dmem_i,
    output logic [7:0]      rdata_o
);
    logic [7:0] mem [0:16383];

    // Each byte starts from a pattern of its low address byte, so a read at the wrong offset within a bank is visible.
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
        end
    end

    // The core samples the read data in the same cycle that it presents the address.
    assign rdata_o = mem[dmem_i.addr];

    // A write lands only on an edge where the core raises its write enable.
    always @(posedge clk_i) begin
        if (dmem_i.we) begin
            mem[dmem_i.addr] <= dmem_i.wdata;
        end
    end
endmodule

// ---- verif/mmno_core_tb.sv ----
`timescale 1ns/1ns
module mmno_core_tb;
    import mmno_pkg::*;
    logic           clk_i         = 1'b0;
    logic           rst_i         = 1'b1;
    logic [15:0]    instr_i       = 16'h0000;
    logic           instr_valid_i = 1'b0;
    logic           instr_ready_o;
    mmno_dmem_req_t dmem_o;
    logic [7:0]     dmem_rdata_i;
    logic           wb_cyc_i      = 1'b0;
    logic           wb_stb_i      = 1'b0;
    logic           wb_we_i       = 1'b0;
    logic [7:0]     wb_adr_i      = 8'h00;
    logic [3:0]     wb_sel_i      = 4'h0;
    logic [31:0]    wb_dat_i      = 32'h0000_0000;
    logic [31:0]    wb_dat_o;
    logic           wb_ack_o;
    int             error_cnt     = 0;
    int             comparisons   = 0;

    // Free-running 250 MHz clock.
    always #2 clk_i = ~clk_i;

    mmno_core DUT (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
        .instr_ready_o(instr_ready_o), .dmem_o(dmem_o), .dmem_rdata_i(dmem_rdata_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    mmno_dfile_model DFILE (.clk_i(clk_i), .dmem_i(dmem_o), .rdata_o(dmem_rdata_i));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request stays put until ack is seen at an edge.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        chk(wb_ack_o, 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, adr, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        chk(r, exp);
    endtask

    // Issues one word in Q1, then watches the next four quarters; a write pulse belongs in Q4 only.
    task automatic run(input logic [15:0] w, input logic wr_exp, output logic [13:0] a);
        int n;
        n = 0;
        instr_i       <= w;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        while (instr_ready_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        chk(instr_ready_o, 1'b1);
        instr_valid_i <= 1'b0;
        for (int c = 1; c <= 4; c++) begin
            if (c > 1) @(posedge clk_i);
            #1;
            if (c == 1) a = dmem_o.addr;
            chk(dmem_o.we, (c == 3) && wr_exp);
        end
        chk(instr_ready_o, 1'b1);
        @(posedge clk_i);
    endtask

    task automatic t_reset;
        rd_chk(REG_WORK, 32'h0);
        rd_chk(REG_PROD, 32'h0);
        wr(8'h1c, 32'hff);
        rd_chk(8'h1c, 32'h0);
    endtask

    task automatic t_move;
        logic [13:0] a;
        wr(REG_WORK, 32'h4f);
        wr(REG_BANK, 32'h2);
        wr(REG_STAT, 32'h15);
        run(16'h6fff, 1'b1, a);
        chk(a, 14'h2ff);
        chk(DFILE.mem[14'h2ff], 8'h4f);
        rd_chk(REG_STAT, 32'h15);
        run(16'h6e60, 1'b1, a);
        chk(a, 14'h3f60);
        run(16'h6e10, 1'b1, a);
        chk(a, 14'h0010);
    endtask

    // Extended set on: the offset path ends at 5Fh, above it the access bank returns.
    task automatic t_index;
        logic [13:0] a;
        wr(REG_CTRL, 32'h1);
        wr(REG_INDEX, 32'h100);
        run(16'h6e5f, 1'b1, a);
        chk(a, 14'h015f);
        run(16'h6e60, 1'b1, a);
        chk(a, 14'h3f60);
        run(16'h6f5f, 1'b1, a);
        chk(a, 14'h025f);
        wr(REG_CTRL, 32'h0);
    endtask

    task automatic t_mul;
        logic [13:0] a;
        wr(REG_WORK, 32'he2);
        run(16'h0dc4, 1'b0, a);
        rd_chk(REG_PROD, 32'had08);
        rd_chk(REG_WORK, 32'he2);
        rd_chk(REG_STAT, 32'h15);
        wr(REG_WORK, 32'hc4);
        DFILE.mem[14'h205] = 8'hb5;
        run(16'h0305, 1'b0, a);
        chk(a, 14'h205);
        rd_chk(REG_PROD, 32'h8a94);
        chk(DFILE.mem[14'h205], 8'hb5);
        wr(REG_WORK, 32'h0);
        run(16'h0305, 1'b0, a);
        rd_chk(REG_PROD, 32'h0);
        rd_chk(REG_STAT, 32'h15);
    endtask

    // Edge operands: zero, the most negative byte, a clear low nibble, plain values.
    task automatic t_neg;
        logic [7:0]  vals [5] = '{8'h3a, 8'h00, 8'h80, 8'h10, 8'h01};
        logic [7:0]  v;
        logic [7:0]  r;
        logic [13:0] a;
        for (int i = 0; i < 5; i++) begin
            v = vals[i];
            r = ~v + 8'h01;
            DFILE.mem[14'h230 + i] = v;
            run({8'h6d, 8'h30 + i[7:0]}, 1'b1, a);
            chk(DFILE.mem[14'h230 + i], r);
            rd_chk(REG_STAT, {27'h0, r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00});
        end
    endtask

    task automatic t_nop;
        logic [15:0] w [3] = '{16'h0000, 16'hf123, 16'hffff};
        logic [13:0] a;
        wr(REG_PROD, 32'h1234);
        wr(REG_STAT, 32'h0a);
        for (int i = 0; i < 3; i++) begin
            run(w[i], 1'b0, a);
            rd_chk(REG_CORE, 32'h12);
            rd_chk(REG_PROD, 32'h1234);
            rd_chk(REG_STAT, 32'h0a);
        end
    endtask

    task automatic final_report;
        $display("Errors: %0d, comparisons: %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence after a six-cycle reset.
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_move();
        t_index();
        t_mul();
        t_neg();
        t_nop();
        final_report();
    end

    // The whole run needs a few hundred cycles; this limit only cuts a hang short.
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule
